// ### src/snb_pkg.sv
// package: constants and types for the switch node bitrate configuration block
`default_nettype none
package snb_pkg;
  localparam logic [6:0] NODE_OFFSET     = 7'h01;
  localparam logic [6:0] ADDR_MAX_NORMAL = 7'h59;
  localparam logic [6:0] ADDR_LEGACY     = 7'h61;
  localparam logic [6:0] ADDR_PROTO_V3   = 7'h62;
  localparam logic [6:0] ADDR_PROTO_V4   = 7'h63;
  localparam logic [3:0] BR_POS_MAX      = 4'h7;
  localparam logic [3:0] BR_POS_RESERVED = 4'h8;
  localparam logic [3:0] BR_POS_SOFT     = 4'h9;
  localparam logic [6:0] SOFT_NODE_RST   = 7'h1F;
  localparam logic [7:0] SOFT_BR_RST     = 8'h00;
  localparam logic [3:0] FC_TPDO1        = 4'h3;
  localparam int         MAX_PAYLOAD     = 8;
  localparam int         POS_WIDTH       = 32;
  localparam int         TIMER_WIDTH     = 16;
  // 1 ms tick at 200 MHz
  localparam int         TICK_NS         = 1000000;
  localparam int         CLK_NS          = 5;
  localparam int         TICK_CYCLES     = TICK_NS / CLK_NS;

  typedef enum logic [1:0]
  {
    MODE_POLLED = 2'b00,
    MODE_CYCLIC = 2'b01,
    MODE_SYNC   = 2'b10
  } snb_mode_t;

  typedef enum logic [1:0]
  {
    PROTO_V4     = 2'b00,
    PROTO_V3     = 2'b01,
    PROTO_LEGACY = 2'b10
  } snb_proto_t;

  typedef enum logic [1:0]
  {
    ST_SAMPLE = 2'b00,
    ST_RUN    = 2'b01
  } snb_state_t;
endpackage
`default_nettype wire

// ### src/snb_fifo_if.sv
// interface: valid/ready stream carrying position frames
`default_nettype none
interface snb_fifo_if #(parameter int WIDTH = 32);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ### src/snb_fifo.sv
// module: synchronous fifo with valid/ready on both sides
`default_nettype none
module snb_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // streams
  snb_fifo_if.snk   wr,
  snb_fifo_if.src   rd
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_reg;
  logic [AW-1:0]    wp_next;
  logic [AW-1:0]    rp_reg;
  logic [AW-1:0]    rp_next;
  logic [AW:0]      cnt_reg;
  logic [AW:0]      cnt_next;
  logic             push;
  logic             pop;

  assign wr.ready = (cnt_reg != (AW+1)'(DEPTH));
  assign rd.valid = (cnt_reg != '0);
  assign rd.data  = mem[rp_reg];
  assign push     = wr.valid && wr.ready;
  assign pop      = rd.valid && rd.ready;

  always_comb
  begin
    wp_next  = push ? wp_reg + AW'(1) : wp_reg;
    rp_next  = pop ? rp_reg + AW'(1) : rp_reg;
    cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      wp_reg  <= wp_next;
      rp_reg  <= rp_next;
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (push)
    begin
      mem[wp_reg] <= wr.data;
    end
  end
endmodule
`default_nettype wire

// ### src/snb_top.sv
// module: switch decode, node and bit rate selection, position transmit scheduling
//
// Behaviour
// - node number is the decimal address switch value plus one.
// - address 98 selects version 3 protocol behaviour.
// - address 99 selects version 4; address 97 restores legacy class behaviour.
// - bit-rate positions 0..7 mean 20,50,100,125,250,500,800,1000 kbit/s.
// - position 9 takes node and rate from software; 8 is reserved.
// - lowest identifier wins arbitration and continues undisturbed.
// - arbitration loser aborts at once and retries the same message.
// - message is one identifier plus at most eight data bytes.
// - identifier is function code combined with own node number.
// - polled mode sends position only on request.
// - cyclic mode sends position at a software adjustable interval.
// - sync mode sends once every n received syncs, n at least one.
// - software addressing uses stored value plus one; default gives node 32.
// - software rate code 00h..07h maps like switches; default 20 kbit/s.
`default_nettype none
module snb_top #(
  parameter int DEPTH = 16,
  parameter int TICK  = snb_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // rotary switches
  input  wire logic [3:0]  tens_address_switch,
  input  wire logic [3:0]  units_address_switch,
  input  wire logic [3:0]  bit_rate_switch,
  // software configuration
  input  wire logic [6:0]  soft_node_value,
  input  wire logic        soft_node_load,
  input  wire logic [7:0]  soft_bit_rate_code,
  input  wire logic        soft_bit_rate_load,
  input  wire logic [1:0]  tx_mode,
  input  wire logic [15:0] cyclic_interval,
  input  wire logic [7:0]  sync_divider,
  // network events and position
  input  wire logic        poll_request,
  input  wire logic        sync_received,
  input  wire logic [31:0] position_value,
  // frame output to controller
  output logic             frame_valid,
  input  wire logic        frame_ready,
  output logic [10:0]      frame_cob_id,
  output logic [3:0]       frame_dlc,
  output logic [31:0]      frame_data,
  // decoded configuration and fifo overflow flag
  output logic [6:0]       node_number,
  output logic [9:0]       bit_rate_kbps,
  output logic             bit_rate_valid,
  output logic             soft_config_mode,
  output logic [1:0]       protocol_sel,
  output logic             legacy_class_behaviour,
  output logic             address_reserved,
  output logic             fifo_overflow
);
  snb_fifo_if #(.WIDTH(32)) fin ();
  snb_fifo_if #(.WIDTH(32)) fout ();

  snb_fifo #(.WIDTH(32), .DEPTH(DEPTH)) u_fifo (
    .sys_clk (sys_clk),
    .rst     (rst),
    .wr      (fin),
    .rd      (fout)
  );

  function automatic logic [9:0] rate_of(input logic [3:0] code);
    case (code)
      4'h0:    rate_of = 10'h014;
      4'h1:    rate_of = 10'h032;
      4'h2:    rate_of = 10'h064;
      4'h3:    rate_of = 10'h07D;
      4'h4:    rate_of = 10'h0FA;
      4'h5:    rate_of = 10'h1F4;
      4'h6:    rate_of = 10'h320;
      4'h7:    rate_of = 10'h3E8;
      default: rate_of = 10'h000;
    endcase
  endfunction

  // configuration state
  snb_pkg::snb_state_t st_reg;
  snb_pkg::snb_state_t st_next;
  logic [6:0]          addr_reg;
  logic [6:0]          addr_next;
  logic [3:0]          brs_reg;
  logic [3:0]          brs_next;
  logic [6:0]          snode_reg;
  logic [6:0]          snode_next;
  logic [7:0]          sbr_reg;
  logic [7:0]          sbr_next;
  logic [6:0]          node_next;
  logic [9:0]          rate_next;
  logic                rvalid_next;
  logic                soft_next;
  logic [1:0]          proto_next;
  logic                legacy_next;
  logic                resv_next;

  // switch capture, once after reset
  always_comb
  begin
    st_next   = st_reg;
    addr_next = addr_reg;
    brs_next  = brs_reg;
    case (st_reg)
      snb_pkg::ST_SAMPLE:
      begin
        addr_next = 7'(tens_address_switch) * 7'h0A + 7'(units_address_switch);
        brs_next  = bit_rate_switch;
        st_next   = snb_pkg::ST_RUN;
      end
      snb_pkg::ST_RUN:
      begin
        st_next = snb_pkg::ST_RUN;
      end
      default: st_next = snb_pkg::ST_SAMPLE;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      st_reg   <= snb_pkg::ST_SAMPLE;
      addr_reg <= '0;
      brs_reg  <= '0;
    end
    else
    begin
      st_reg   <= st_next;
      addr_reg <= addr_next;
      brs_reg  <= brs_next;
    end
  end

  // software node and rate store, loadable at any time
  always_comb
  begin
    snode_next = soft_node_load ? soft_node_value : snode_reg;
    sbr_next   = soft_bit_rate_load ? soft_bit_rate_code : sbr_reg;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      snode_reg <= snb_pkg::SOFT_NODE_RST;
      sbr_reg   <= snb_pkg::SOFT_BR_RST;
    end
    else
    begin
      snode_reg <= snode_next;
      sbr_reg   <= sbr_next;
    end
  end

  // decoded configuration outputs
  always_comb
  begin
    soft_next   = (brs_reg == snb_pkg::BR_POS_SOFT);
    resv_next   = (addr_reg > snb_pkg::ADDR_MAX_NORMAL);
    proto_next  = snb_pkg::PROTO_V4;
    legacy_next = legacy_class_behaviour;
    case (addr_reg)
      snb_pkg::ADDR_PROTO_V3: proto_next = snb_pkg::PROTO_V3;
      snb_pkg::ADDR_PROTO_V4: proto_next = snb_pkg::PROTO_V4;
      snb_pkg::ADDR_LEGACY:
      begin
        proto_next  = snb_pkg::PROTO_LEGACY;
        legacy_next = 1'b1;
      end
      default: proto_next = snb_pkg::PROTO_V4;
    endcase
    if (soft_next)
    begin
      node_next   = snode_reg + snb_pkg::NODE_OFFSET;
      rate_next   = (sbr_reg <= 8'(snb_pkg::BR_POS_MAX)) ? rate_of(sbr_reg[3:0]) : 10'd0;
      rvalid_next = (sbr_reg <= 8'(snb_pkg::BR_POS_MAX));
    end
    else
    begin
      node_next   = addr_reg + snb_pkg::NODE_OFFSET;
      rate_next   = rate_of(brs_reg);
      rvalid_next = (brs_reg <= snb_pkg::BR_POS_MAX);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      node_number            <= snb_pkg::NODE_OFFSET;
      bit_rate_kbps          <= '0;
      bit_rate_valid         <= 1'b0;
      soft_config_mode       <= 1'b0;
      protocol_sel           <= snb_pkg::PROTO_V4;
      legacy_class_behaviour <= 1'b0;
      address_reserved       <= 1'b0;
    end
    else
    begin
      node_number            <= node_next;
      bit_rate_kbps          <= rate_next;
      bit_rate_valid         <= rvalid_next;
      soft_config_mode       <= soft_next;
      protocol_sel           <= proto_next;
      legacy_class_behaviour <= legacy_next;
      address_reserved       <= resv_next;
    end
  end

  // transmit scheduling
  logic [17:0] tick_reg;
  logic [17:0] tick_next;
  logic [15:0] cyc_reg;
  logic [15:0] cyc_next;
  logic [7:0]  sync_reg;
  logic [7:0]  sync_next;
  logic        fire;
  logic        ovf_next;
  logic [7:0]  n_eff;

  always_comb
  begin
    fire      = 1'b0;
    tick_next = tick_reg;
    cyc_next  = cyc_reg;
    sync_next = sync_reg;
    n_eff     = (sync_divider == 8'h00) ? 8'h01 : sync_divider;
    case (snb_pkg::snb_mode_t'(tx_mode))
      // counters of idle modes sit at zero so each mode starts a fresh count
      snb_pkg::MODE_POLLED:
      begin
        tick_next = '0;
        cyc_next  = '0;
        sync_next = '0;
        fire      = poll_request;
      end
      snb_pkg::MODE_CYCLIC:
      begin
        sync_next = '0;
        tick_next = (tick_reg >= 18'(TICK - 1)) ? 18'h00000 : tick_reg + 18'h00001;
        if (tick_reg >= 18'(TICK - 1) && cyclic_interval != 16'h0000)
        begin
          if (cyc_reg + 16'h0001 >= cyclic_interval)
          begin
            cyc_next = 16'h0000;
            fire     = 1'b1;
          end
          else
          begin
            cyc_next = cyc_reg + 16'h0001;
          end
        end
      end
      snb_pkg::MODE_SYNC:
      begin
        tick_next = '0;
        cyc_next  = '0;
        if (sync_received)
        begin
          if (sync_reg + 8'h01 >= n_eff)
          begin
            sync_next = 8'h00;
            fire      = 1'b1;
          end
          else
          begin
            sync_next = sync_reg + 8'h01;
          end
        end
      end
      default:
      begin
        tick_next = '0;
        cyc_next  = '0;
        sync_next = '0;
        fire      = 1'b0;
      end
    endcase
    if (st_reg != snb_pkg::ST_RUN)
    begin
      fire = 1'b0;
    end
    ovf_next = fifo_overflow | (fire & ~fin.ready);
  end

  assign fin.valid  = fire;
  assign fin.data   = position_value;
  assign fout.ready = ~frame_valid | frame_ready;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      tick_reg      <= '0;
      cyc_reg       <= '0;
      sync_reg      <= '0;
      fifo_overflow <= 1'b0;
    end
    else
    begin
      tick_reg      <= tick_next;
      cyc_reg       <= cyc_next;
      sync_reg      <= sync_next;
      fifo_overflow <= ovf_next;
    end
  end

  // output frame; held until taken, so a lost arbitration retries the same word
  logic        fv_next;
  logic [10:0] cob_next;
  logic [3:0]  dlc_next;
  logic [31:0] fdata_next;

  always_comb
  begin
    fv_next    = frame_valid;
    cob_next   = frame_cob_id;
    dlc_next   = frame_dlc;
    fdata_next = frame_data;
    if (fout.ready)
    begin
      fv_next = fout.valid;
      if (fout.valid)
      begin
        cob_next   = {snb_pkg::FC_TPDO1, node_number};
        dlc_next   = 4'h4;
        fdata_next = fout.data;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      frame_valid  <= 1'b0;
      frame_cob_id <= '0;
      frame_dlc    <= '0;
      frame_data   <= '0;
    end
    else
    begin
      frame_valid  <= fv_next;
      frame_cob_id <= cob_next;
      frame_dlc    <= dlc_next;
      frame_data   <= fdata_next;
    end
  end
endmodule
`default_nettype wire

// ### testbench/snb_chk_properties.sv
// checker: frame and configuration properties of snb_top
`default_nettype none
module snb_chk (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rst,
  // watched outputs and the frame_ready input
  input wire logic        frame_valid,
  input wire logic        frame_ready,
  input wire logic [10:0] frame_cob_id,
  input wire logic [3:0]  frame_dlc,
  input wire logic [31:0] frame_data,
  input wire logic [6:0]  node_number,
  input wire logic [9:0]  bit_rate_kbps,
  input wire logic        bit_rate_valid,
  input wire logic        soft_config_mode,
  input wire logic [1:0]  protocol_sel,
  input wire logic        legacy_class_behaviour,
  input wire logic        fifo_overflow
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] up_cnt;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // cycles since reset release, saturating
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      up_cnt <= 3'h0;
    else if (up_cnt != 3'h7)
      up_cnt <= up_cnt + 3'h1;
  end
  cob_id_a:
    assert property (frame_valid |-> frame_cob_id == {4'h3, node_number}) else $error("bad id");
  payload_len_a:
    assert property (frame_valid |-> frame_dlc == 4'h4) else $error("bad length");
  frame_hold_a:
    assert property (frame_valid && !frame_ready |=> frame_valid && $stable(frame_data)
      && $stable(frame_cob_id)) else $error("frame changed while waiting");
  rate_set_a:
    assert property (bit_rate_valid |-> bit_rate_kbps inside {10'h014, 10'h032, 10'h064,
      10'h07D, 10'h0FA, 10'h1F4, 10'h320, 10'h3E8}) else $error("bad rate");
  rate_zero_a:
    assert property (!bit_rate_valid |-> bit_rate_kbps == 10'h000) else $error("rate not zero");
  node_hold_a:
    assert property (up_cnt == 3'h7 && !soft_config_mode |=> $stable(node_number))
      else $error("node changed after sampling");
  legacy_sel_a:
    assert property (legacy_class_behaviour == (protocol_sel == 2'h2)) else $error("legacy");
  node_nonzero_a:
    assert property (node_number != 7'h00) else $error("node zero");
  cover property (frame_valid && frame_ready);
  cover property ($rose(fifo_overflow));
  cover property (soft_config_mode && up_cnt == 3'h7);
endmodule
bind snb_top snb_chk u_snb_chk (.*);
`default_nettype wire

// ### testbench/snb_sink.sv
// model: frame consumer that stalls or accepts slowly
`default_nettype none
module snb_sink (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // control from bench
  input  wire logic stall,
  input  wire logic slow,
  // frame handshake
  output logic      frame_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] lfsr_reg;
  // a lost arbitration shows as a stall; the frame is offered again
  always_ff @(posedge sys_clk)
  begin
    lfsr_reg    <= rst ? 8'hA5 : {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5]};
    frame_ready <= !rst && !stall && (!slow || lfsr_reg[0]);
  end
endmodule
`default_nettype wire

// ### testbench/tb.sv
// bench: switch decode, software settings and frame scheduling
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        sys_clk = 1'b0, rst = 1'b1, stall = 1'b0, slow = 1'b0;
  logic [3:0]  tens_address_switch = 4'h0, units_address_switch = 4'h0, bit_rate_switch = 4'h0;
  logic [6:0]  soft_node_value = 7'h00;
  logic        soft_node_load = 1'b0, soft_bit_rate_load = 1'b0;
  logic [7:0]  soft_bit_rate_code = 8'h00, sync_divider = 8'h00;
  logic [1:0]  tx_mode = 2'h0;
  logic [15:0] cyclic_interval = 16'h0000;
  logic        poll_request = 1'b0, sync_received = 1'b0;
  logic [31:0] position_value = 32'h0, seed = 32'h84DA;
  logic        frame_valid, frame_ready, bit_rate_valid, soft_config_mode;
  logic        legacy_class_behaviour, address_reserved, fifo_overflow;
  logic [10:0] frame_cob_id;
  logic [3:0]  frame_dlc;
  logic [31:0] frame_data;
  logic [6:0]  node_number;
  logic [9:0]  bit_rate_kbps;
  logic [1:0]  protocol_sel;
  int          err_total = 0, checked = 0, cyc = 0, nfr = 0, n;
  logic [31:0] expq [$];
  logic [11:0] corners [7] = '{12'h000, 12'h897, 12'h908, 12'h973, 12'h981, 12'h996, 12'h129};
  logic [9:0]  rates [8] = '{10'h014, 10'h032, 10'h064, 10'h07D, 10'h0FA, 10'h1F4, 10'h320,
    10'h3E8};
  snb_top #(.TICK(4)) u_snb_top (.*);
  snb_sink u_snb_sink (.*);
  always #2.5 sys_clk = ~sys_clk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [9:0] exp_rate(input logic [7:0] c);
    return c < 8'h08 ? rates[c[2:0]] : 10'h000;
  endfunction
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // k back-to-back request cycles; e queues the position for comparison
  task automatic trigs(input logic p, input logic s, input logic e, input int k);
    repeat (k)
    begin
      poll_request = p;
      sync_received = s;
      position_value = rnd();
      if (e)
        expq.push_back(position_value);
      tick(1);
    end
    poll_request = 1'b0;
    sync_received = 1'b0;
  endtask
  task automatic cfg(input logic [3:0] t, input logic [3:0] u, input logic [3:0] b);
    logic [6:0] a;
    a = 7'(t * 7'h0A + u);
    tens_address_switch = t;
    units_address_switch = u;
    bit_rate_switch = b;
    rst = 1'b1;
    tick(6);
    rst = 1'b0;
    tick(4);
    // later switch moves must be ignored
    tens_address_switch = ~t;
    units_address_switch = 4'(rnd());
    bit_rate_switch = ~b;
    tick(2);
    if (b == 4'h9)
      chk(node_number, 7'h20);
    else if (a < 7'h5A)
      chk(node_number, a + 7'h01);
    chk(bit_rate_kbps, b == 4'h9 ? 10'h014 : exp_rate({4'h0, b}));
    chk(bit_rate_valid, b != 4'h8);
    chk(soft_config_mode, b == 4'h9);
    chk(address_reserved, a > 7'h59);
    chk(protocol_sel, a == 7'h61 ? 2'h2 : (a == 7'h62 ? 2'h1 : 2'h0));
    chk(legacy_class_behaviour, a == 7'h61);
  endtask
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      err_total++;
      give_verdict();
    end
    if (frame_valid === 1'b1 && frame_ready === 1'b1)
    begin
      nfr++;
      if (expq.size() != 0)
        chk(frame_data, expq.pop_front());
    end
  end
  initial
  begin
    foreach (corners[i])
      cfg(corners[i][11:8], corners[i][7:4], corners[i][3:0]);
    repeat (3)
    begin
      soft_node_value = 7'(rnd() % 127);
      soft_bit_rate_code = 8'(rnd() % 12);
      soft_node_load = 1'b1;
      soft_bit_rate_load = 1'b1;
      tick(1);
      soft_node_load = 1'b0;
      soft_bit_rate_load = 1'b0;
      tick(3);
      chk(node_number, soft_node_value + 7'h01);
      chk(bit_rate_kbps, exp_rate(soft_bit_rate_code));
      chk(bit_rate_valid, soft_bit_rate_code < 8'h08);
    end
    repeat (5)
      cfg(4'(rnd() % 10), 4'(rnd() % 10), 4'(rnd() % 10));
    cfg(4'h4, 4'h2, 4'h5);
    trigs(1'b1, 1'b0, 1'b1, 1);
    n = 1;
    while (frame_valid !== 1'b1 && n < 20)
    begin
      tick(1);
      n++;
    end
    chk(n, 2);
    chk(frame_cob_id, 11'h1AB);
    chk(frame_dlc, 4'h4);
    tick(2);
    slow = 1'b1;
    n = nfr;
    trigs(1'b1, 1'b0, 1'b1, 3);
    tick(1);
    trigs(1'b0, 1'b1, 1'b0, 2);
    tick(40);
    chk(nfr - n, 3);
    expq.delete();
    tx_mode = 2'h2;
    for (int d = 0; d < 4; d++)
    begin
      sync_divider = 8'(d);
      n = nfr;
      trigs(1'b0, 1'b1, 1'b0, 6);
      tick(1);
      trigs(1'b1, 1'b0, 1'b0, 2);
      tick(40);
      chk(nfr - n, d == 0 ? 6 : 6 / d);
    end
    tx_mode = 2'h1;
    cyclic_interval = 16'h0002;
    n = nfr;
    tick(80);
    chk(nfr - n >= 8 && nfr - n <= 11, 1);
    cyclic_interval = 16'h0000;
    tick(30);
    n = nfr;
    tick(60);
    chk(nfr - n, 0);
    tx_mode = 2'h3;
    trigs(1'b1, 1'b1, 1'b0, 4);
    tick(30);
    chk(nfr - n, 0);
    tx_mode = 2'h0;
    stall = 1'b1;
    chk(fifo_overflow, 0);
    trigs(1'b1, 1'b0, 1'b0, 20);
    tick(2);
    chk(fifo_overflow, 1);
    stall = 1'b0;
    tick(100);
    chk(nfr - n, 17);
    chk(frame_valid, 0);
    give_verdict();
  end
endmodule
`default_nettype wire
